// [core/stc_pkg.sv]
package stc_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [5:0] STC_ADDR_RUN = 6'h00;
    localparam logic [5:0] STC_ADDR_OUT_EN = 6'h01;
    localparam logic [5:0] STC_ADDR_OUT_LEVEL = 6'h02;
    localparam logic [5:0] STC_ADDR_SPLIT = 6'h03;
    localparam logic [5:0] STC_ADDR_CMD_CLR = 6'h04;
    localparam logic [5:0] STC_ADDR_CMD_SET = 6'h05;
    localparam logic [5:0] STC_ADDR_WAVE_MODE = 6'h08;
    localparam logic [5:0] STC_ADDR_INT_EN = 6'h0A;
    localparam logic [5:0] STC_ADDR_INT_FLAGS = 6'h0B;
    localparam logic [5:0] STC_ADDR_DEBUG = 6'h0E;
    localparam logic [5:0] STC_ADDR_LOW_CNT = 6'h20;
    localparam logic [5:0] STC_ADDR_HIGH_CNT = 6'h21;
    localparam logic [5:0] STC_ADDR_LOW_PER = 6'h26;
    localparam logic [5:0] STC_ADDR_HIGH_PER = 6'h27;
    localparam logic [5:0] STC_ADDR_CMP_BASE = 6'h28;

    // ---------------------------------------------------------------
    // field layout and reset values
    // ---------------------------------------------------------------
    localparam int STC_LOW_CH_LSB = 0;
    localparam int STC_HIGH_CH_LSB = 4;
    localparam int STC_INT_CMP_LSB = 4;
    localparam int STC_INT_HIGH_TIMER_UNDERFLOW = 1;
    localparam int STC_INT_LOW_TIMER_UNDERFLOW = 0;
    localparam int STC_CMD_LSB = 2;
    localparam int STC_NUM_CH = 3;
    localparam logic [7:0] STC_CH_MASK = 8'h77;
    localparam logic [7:0] STC_INT_MASK = 8'h73;
    localparam logic [7:0] STC_RESET_ZERO = 8'h00;
    localparam logic [7:0] STC_RESET_PER = 8'hFF;
    localparam logic [7:0] STC_RESET_CMP = 8'h00;

    typedef enum logic [1:0] {
        STC_CMD_NONE,
        STC_CMD_RSVD,
        STC_CMD_RESTART,
        STC_CMD_HARD_RESET
    } stc_cmd_t;

endpackage : stc_pkg

// [core/stc_byte_timer.sv]
`timescale 1ns/10ps
`default_nettype none

// one 8-bit down counter with three compare channels
module stc_byte_timer
    import stc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic count_en,
    input wire logic restart,
    input wire logic hard_reset,
    input wire logic wr_cnt,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] period,
    input wire logic [23:0] compare,
    output logic [7:0] count,
    output logic underflow,
    output logic [2:0] match,
    output logic [2:0] wave
);

    logic [7:0] next_count;

    always_comb begin
        next_count = count;
        if (wr_cnt) begin
            next_count = wr_data;
        end else if (hard_reset) begin
            next_count = STC_RESET_PER;
        end else if (restart) begin
            next_count = period;
        end else if (count_en) begin
            next_count = (count == STC_RESET_ZERO) ? period : count - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= STC_RESET_ZERO;
            underflow <= 1'b0;
        end else begin
            count <= next_count;
            underflow <= count_en && !wr_cnt && !restart && !hard_reset
                         && (count == STC_RESET_ZERO);
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < STC_NUM_CH; ch++) begin : g_ch
            assign match[ch] = count_en && (count == compare[ch*8 +: 8]);
            // single-slope pwm: high while count is at or below compare
            assign wave[ch] = (count <= compare[ch*8 +: 8]);
        end
    endgenerate

endmodule : stc_byte_timer

`default_nettype wire

// [core/stc_split_timer.sv]
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - output-enable register: low enables bits 0-2, high enables bits 4-6, reset zero
// - enabled channel in waveform mode drives pin instead of port output value
// - while timer disabled, idle level bits drive each channel's compare output
// - split select bit makes two separate 8-bit timers with split register map
// - writing one to clear-view clears that bit, zeros leave bits unchanged
// - writing one to set-view sets that bit, zeros leave bits unchanged
// - command 0 none, 1 reserved, 2 forced restart, 3 forced hard reset
// - command field acts only on write and always reads zero
// - hard reset command ignored while the timer is enabled
// - target 0 none, 1 low timer, 2 high timer, 3 both
// - interrupt enables: compare 4-6, high underflow bit 1, low underflow bit 0
// - low compare flag sets while counting when low counter equals that channel's compare
// - low compare flags clear only by software writing one
// - high underflow flag sets at high timer bottom, cleared by writing one
// - low underflow flag sets at low timer bottom, cleared by writing one
// - run-in-debug zero halts timer in debug break, one keeps it running
// - software counter write beats counting, clearing and reloading
module stc_split_timer
    import stc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic debug_halt,
    input wire logic [5:0] port_out,
    output logic [5:0] waveform_pin,
    output logic irq
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic timer_enable;
    logic [7:0] channel_output_enable;
    logic [7:0] channel_output_level;
    logic dual_8bit_select;
    logic [1:0] command_target_select;
    logic frequency_waveform_mode;
    logic [7:0] interrupt_enable;
    logic [7:0] interrupt_flags;
    logic run_while_halted;
    logic [7:0] low_period;
    logic [7:0] high_period;
    logic [7:0] low_compare [STC_NUM_CH];
    logic [7:0] high_compare [STC_NUM_CH];
    logic debug_sync1;
    logic debug_sync2;

    logic [7:0] low_counter_value;
    logic [7:0] high_count;
    logic low_timer_underflow;
    logic high_timer_underflow;
    logic [2:0] low_compare_channel;
    logic [2:0] low_wave;
    logic [2:0] high_wave;
    logic count_en;
    logic cmd_write;
    stc_cmd_t cmd;
    logic [1:0] cmd_target;
    logic low_restart;
    logic high_restart;
    logic low_hard;
    logic high_hard;
    logic [23:0] low_cmp_flat;
    logic [23:0] high_cmp_flat;
    logic [7:0] next_flags;
    logic [5:0] next_pin;

    // ---------------------------------------------------------------
    // debug halt synchroniser
    // ---------------------------------------------------------------
    // only the second stage feeds logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            debug_sync1 <= 1'b0;
            debug_sync2 <= 1'b0;
        end else begin
            debug_sync1 <= debug_halt;
            debug_sync2 <= debug_sync1;
        end
    end

    // halted in break unless run-in-debug is set
    assign count_en = timer_enable && dual_8bit_select
                      && (run_while_halted || !debug_sync2);

    // ---------------------------------------------------------------
    // commands
    // ---------------------------------------------------------------
    assign cmd_write = wr && (addr == STC_ADDR_CMD_CLR || addr == STC_ADDR_CMD_SET);
    assign cmd = stc_cmd_t'(wdata[STC_CMD_LSB +: 2]);
    // set view ors the written target in, clear view strips it
    assign cmd_target = (addr == STC_ADDR_CMD_SET) ?
                        (command_target_select | wdata[1:0]) :
                        (command_target_select & ~wdata[1:0]);

    // only the set view carries a command; the clear view strips targets
    always_comb begin
        low_restart = 1'b0;
        high_restart = 1'b0;
        low_hard = 1'b0;
        high_hard = 1'b0;
        if (cmd_write && addr == STC_ADDR_CMD_SET) begin
            unique case (cmd)
                STC_CMD_NONE, STC_CMD_RSVD: begin
                end
                STC_CMD_RESTART: begin
                    low_restart = wdata[0];
                    high_restart = wdata[1];
                end
                STC_CMD_HARD_RESET: begin
                    // both timers must be picked; enabled timer ignores it
                    low_hard = !timer_enable && (wdata[1:0] == 2'b11);
                    high_hard = !timer_enable && (wdata[1:0] == 2'b11);
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    // writes to unmapped offsets fall through and change nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_enable <= 1'b0;
            channel_output_enable <= STC_RESET_ZERO;
            channel_output_level <= STC_RESET_ZERO;
            dual_8bit_select <= 1'b0;
            command_target_select <= 2'b00;
            frequency_waveform_mode <= 1'b0;
            interrupt_enable <= STC_RESET_ZERO;
            run_while_halted <= 1'b0;
        end else if (wr) begin
            unique case (addr)
                STC_ADDR_RUN: timer_enable <= wdata[0];
                STC_ADDR_OUT_EN: channel_output_enable <= wdata & STC_CH_MASK;
                STC_ADDR_OUT_LEVEL: channel_output_level <= wdata & STC_CH_MASK;
                STC_ADDR_SPLIT: dual_8bit_select <= wdata[0];
                STC_ADDR_CMD_CLR, STC_ADDR_CMD_SET: command_target_select <= cmd_target;
                STC_ADDR_WAVE_MODE: frequency_waveform_mode <= wdata[0];
                STC_ADDR_INT_EN: interrupt_enable <= wdata & STC_INT_MASK;
                STC_ADDR_DEBUG: run_while_halted <= wdata[0];
                default: begin
                end
            endcase
        end
    end

    // hard reset returns the low timer setup to its reset values
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_period <= STC_RESET_PER;
            for (int i = 0; i < STC_NUM_CH; i++) begin
                low_compare[i] <= STC_RESET_CMP;
            end
        end else if (low_hard) begin
            low_period <= STC_RESET_PER;
            for (int i = 0; i < STC_NUM_CH; i++) begin
                low_compare[i] <= STC_RESET_CMP;
            end
        end else if (wr) begin
            if (addr == STC_ADDR_LOW_PER) begin
                low_period <= wdata;
            end
            for (int i = 0; i < STC_NUM_CH; i++) begin
                if (addr == STC_ADDR_CMP_BASE + 6'(2 * i)) begin
                    low_compare[i] <= wdata;
                end
            end
        end
    end

    // hard reset returns the high timer setup to its reset values
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_period <= STC_RESET_PER;
            for (int i = 0; i < STC_NUM_CH; i++) begin
                high_compare[i] <= STC_RESET_CMP;
            end
        end else if (high_hard) begin
            high_period <= STC_RESET_PER;
            for (int i = 0; i < STC_NUM_CH; i++) begin
                high_compare[i] <= STC_RESET_CMP;
            end
        end else if (wr) begin
            if (addr == STC_ADDR_HIGH_PER) begin
                high_period <= wdata;
            end
            for (int i = 0; i < STC_NUM_CH; i++) begin
                if (addr == STC_ADDR_CMP_BASE + 6'(2 * i + 1)) begin
                    high_compare[i] <= wdata;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // the two byte timers
    // ---------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < STC_NUM_CH; c++) begin : g_flat
            assign low_cmp_flat[c*8 +: 8] = low_compare[c];
            assign high_cmp_flat[c*8 +: 8] = high_compare[c];
        end
    endgenerate

    stc_byte_timer u_low (
        .clk(clk),
        .rst_n(rst_n),
        .count_en(count_en),
        .restart(low_restart),
        .hard_reset(low_hard),
        .wr_cnt(wr && addr == STC_ADDR_LOW_CNT),
        .wr_data(wdata),
        .period(low_period),
        .compare(low_cmp_flat),
        .count(low_counter_value),
        .underflow(low_timer_underflow),
        .match(low_compare_channel),
        .wave(low_wave)
    );

    stc_byte_timer u_high (
        .clk(clk),
        .rst_n(rst_n),
        .count_en(count_en),
        .restart(high_restart),
        .hard_reset(high_hard),
        .wr_cnt(wr && addr == STC_ADDR_HIGH_CNT),
        .wr_data(wdata),
        .period(high_period),
        .compare(high_cmp_flat),
        .count(high_count),
        .underflow(high_timer_underflow),
        .match(),
        .wave(high_wave)
    );

    // ---------------------------------------------------------------
    // interrupt flags: set beats a same-cycle clear
    // ---------------------------------------------------------------
    always_comb begin
        next_flags = interrupt_flags;
        if (wr && addr == STC_ADDR_INT_FLAGS) begin
            next_flags = interrupt_flags & ~(wdata & STC_INT_MASK);
        end
        next_flags[STC_INT_CMP_LSB +: 3] = next_flags[STC_INT_CMP_LSB +: 3]
                                           | low_compare_channel;
        next_flags[STC_INT_HIGH_TIMER_UNDERFLOW] = next_flags[STC_INT_HIGH_TIMER_UNDERFLOW] | high_timer_underflow;
        next_flags[STC_INT_LOW_TIMER_UNDERFLOW] = next_flags[STC_INT_LOW_TIMER_UNDERFLOW] | low_timer_underflow;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_flags <= STC_RESET_ZERO;
            irq <= 1'b0;
        end else begin
            interrupt_flags <= next_flags;
            // irq tracks the flags that this same edge stores
            irq <= |(next_flags & interrupt_enable);
        end
    end

    // ---------------------------------------------------------------
    // waveform pins
    // ---------------------------------------------------------------
    // low channels on pins 2:0, high channels on pins 5:3
    always_comb begin
        for (int i = 0; i < STC_NUM_CH; i++) begin
            if (!timer_enable) begin
                next_pin[i] = channel_output_level[STC_LOW_CH_LSB + i];
                next_pin[i + 3] = channel_output_level[STC_HIGH_CH_LSB + i];
            end else begin
                next_pin[i] = (channel_output_enable[STC_LOW_CH_LSB + i]
                              && frequency_waveform_mode) ? low_wave[i] : port_out[i];
                next_pin[i + 3] = (channel_output_enable[STC_HIGH_CH_LSB + i]
                                  && frequency_waveform_mode) ? high_wave[i]
                                  : port_out[i + 3];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            waveform_pin <= 6'h00;
        end else begin
            waveform_pin <= next_pin;
        end
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= STC_RESET_ZERO;
        end else if (rd) begin
            unique case (addr)
                STC_ADDR_RUN: rdata <= {7'h00, timer_enable};
                STC_ADDR_OUT_EN: rdata <= channel_output_enable;
                STC_ADDR_OUT_LEVEL: rdata <= channel_output_level;
                STC_ADDR_SPLIT: rdata <= {7'h00, dual_8bit_select};
                // command bits never read back, only the stored targets
                STC_ADDR_CMD_CLR, STC_ADDR_CMD_SET:
                    rdata <= {6'h00, command_target_select};
                STC_ADDR_WAVE_MODE: rdata <= {7'h00, frequency_waveform_mode};
                STC_ADDR_INT_EN: rdata <= interrupt_enable;
                STC_ADDR_INT_FLAGS: rdata <= interrupt_flags;
                STC_ADDR_DEBUG: rdata <= {7'h00, run_while_halted};
                STC_ADDR_LOW_CNT: rdata <= low_counter_value;
                STC_ADDR_HIGH_CNT: rdata <= high_count;
                STC_ADDR_LOW_PER: rdata <= low_period;
                STC_ADDR_HIGH_PER: rdata <= high_period;
                STC_ADDR_CMP_BASE: rdata <= low_compare[0];
                STC_ADDR_CMP_BASE + 6'h01: rdata <= high_compare[0];
                STC_ADDR_CMP_BASE + 6'h02: rdata <= low_compare[1];
                STC_ADDR_CMP_BASE + 6'h03: rdata <= high_compare[1];
                STC_ADDR_CMP_BASE + 6'h04: rdata <= low_compare[2];
                STC_ADDR_CMP_BASE + 6'h05: rdata <= high_compare[2];
                default: rdata <= STC_RESET_ZERO;
            endcase
        end else begin
            // read data stand only in the cycle after the strobe
            rdata <= STC_RESET_ZERO;
        end
    end

endmodule : stc_split_timer

`default_nettype wire

// [sim/stc_split_timer_checker.sv]
`timescale 1ns/10ps
`default_nettype none

module stc_split_timer_checker
    import stc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic debug_halt,
    input wire logic [5:0] port_out,
    input wire logic [5:0] waveform_pin,
    input wire logic irq
);
    // ----------------------------------------
    // shadow copies of the control registers
    // ----------------------------------------
    logic run_sh;
    logic wm_sh;
    logic [7:0] lvl_sh;
    logic [7:0] oe_sh;
    logic [7:0] ie_sh;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_sh <= 1'b0;
            wm_sh <= 1'b0;
            lvl_sh <= 8'h00;
            oe_sh <= 8'h00;
            ie_sh <= 8'h00;
        end else if (wr) begin
            case (addr)
                STC_ADDR_RUN: run_sh <= wdata[0];
                STC_ADDR_WAVE_MODE: wm_sh <= wdata[0];
                STC_ADDR_OUT_LEVEL: lvl_sh <= wdata & STC_CH_MASK;
                STC_ADDR_OUT_EN: oe_sh <= wdata & STC_CH_MASK;
                STC_ADDR_INT_EN: ie_sh <= wdata & STC_INT_MASK;
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_cmd_reads_zero: assert property (
        rd && (addr == STC_ADDR_CMD_CLR || addr == STC_ADDR_CMD_SET) |=> rdata[7:2] == 6'h00)
        else $error("command bits read nonzero");
    chk_chan_mask: assert property (
        rd && (addr == STC_ADDR_OUT_EN || addr == STC_ADDR_OUT_LEVEL)
        |=> (rdata & ~STC_CH_MASK) == 8'h00)
        else $error("channel register reserved bits set");
    chk_split_bits: assert property (rd && addr == STC_ADDR_SPLIT |=> rdata[7:1] == 7'h00)
        else $error("split register reserved bits set");
    chk_debug_bits: assert property (rd && addr == STC_ADDR_DEBUG |=> rdata[7:1] == 7'h00)
        else $error("debug register reserved bits set");
    chk_int_mask: assert property (
        rd && (addr == STC_ADDR_INT_EN || addr == STC_ADDR_INT_FLAGS)
        |=> (rdata & ~STC_INT_MASK) == 8'h00)
        else $error("interrupt register reserved bits set");
    chk_irq_masked: assert property ($past(ie_sh) == 8'h00 |-> !irq)
        else $error("irq high with all enables clear");
    chk_idle_level: assert property (
        !$past(run_sh) |-> waveform_pin == {$past(lvl_sh[6:4]), $past(lvl_sh[2:0])})
        else $error("pins differ from idle levels");
    chk_port_pass: assert property (
        $past(run_sh) && (!$past(wm_sh) || $past(oe_sh) == 8'h00)
        |-> waveform_pin == $past(port_out))
        else $error("pins differ from port output");
    chk_cnt_write: assert property (
        wr && addr == STC_ADDR_LOW_CNT ##2 rd && addr == STC_ADDR_LOW_CNT
        |=> rdata == $past(wdata, 3))
        else $error("counter write lost");
    chk_hard_reset: assert property (
        wr && addr == STC_ADDR_CMD_SET && wdata == 8'h0F && !run_sh
        ##2 rd && addr == STC_ADDR_LOW_CNT |=> rdata == 8'hFF)
        else $error("hard reset did not load counter");
endmodule : stc_split_timer_checker

`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end

module tb
    import stc_pkg::*;
;
    logic clk;
    logic rst_n;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic debug_halt;
    logic [5:0] port_out;
    logic [5:0] waveform_pin;
    logic irq;
    int failures;
    int checks;
    int n;
    logic [7:0] v;
    logic [7:0] v2;
    logic [5:0] ra [5] = '{STC_ADDR_OUT_EN, STC_ADDR_OUT_LEVEL, STC_ADDR_SPLIT,
        STC_ADDR_INT_EN, STC_ADDR_DEBUG};
    logic [7:0] rm [5] = '{8'h77, 8'h77, 8'h01, 8'h73, 8'h01};

    stc_split_timer dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .debug_halt(debug_halt), .port_out(port_out),
        .waveform_pin(waveform_pin), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ----------------------------------------
    // register bus tasks
    // ----------------------------------------
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic chk_reg(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        `CHK(d, e)
    endtask : chk_reg

    task automatic chk_out(input logic [5:0] ep, input logic ei);
        repeat (3) @(posedge clk);
        #1;
        `CHK(waveform_pin, ep)
        `CHK(irq, ei)
    endtask : chk_out

    task automatic test_done;
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    initial begin
        rst_n = 1'b0;
        addr = 6'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        debug_halt = 1'b0;
        port_out = 6'h00;
        failures = 0;
        checks = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) chk_reg(ra[i], 8'h00);
        chk_reg(STC_ADDR_INT_FLAGS, 8'h00);
        chk_reg(STC_ADDR_LOW_PER, 8'hFF);
        wr_reg(6'h06, 8'hFF);
        chk_reg(6'h06, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr_reg(ra[i], 8'hFF);
            chk_reg(ra[i], rm[i]);
            wr_reg(ra[i], 8'h00);
        end
        wr_reg(STC_ADDR_OUT_LEVEL, 8'h55);
        chk_out(6'h2D, 1'b0);
        wr_reg(STC_ADDR_OUT_LEVEL, 8'h00);
        // ----------------------------------------
        // set and clear views of the target bits
        // ----------------------------------------
        wr_reg(STC_ADDR_CMD_SET, 8'h01);
        chk_reg(STC_ADDR_CMD_CLR, 8'h01);
        wr_reg(STC_ADDR_CMD_SET, 8'h02);
        chk_reg(STC_ADDR_CMD_SET, 8'h03);
        wr_reg(STC_ADDR_CMD_CLR, 8'h01);
        chk_reg(STC_ADDR_CMD_SET, 8'h02);
        wr_reg(STC_ADDR_CMD_CLR, 8'h03);
        wr_reg(STC_ADDR_LOW_CNT, 8'h12);
        chk_reg(STC_ADDR_LOW_CNT, 8'h12);
        wr_reg(STC_ADDR_CMD_SET, 8'h0F);
        chk_reg(STC_ADDR_LOW_CNT, 8'hFF);
        chk_reg(STC_ADDR_CMD_SET, 8'h03);
        wr_reg(STC_ADDR_CMD_CLR, 8'h03);
        // ----------------------------------------
        // commands while enabled and halted
        // ----------------------------------------
        debug_halt <= 1'b1;
        wr_reg(STC_ADDR_SPLIT, 8'h01);
        wr_reg(STC_ADDR_RUN, 8'h01);
        wr_reg(STC_ADDR_LOW_CNT, 8'h40);
        wr_reg(STC_ADDR_HIGH_CNT, 8'h50);
        chk_reg(STC_ADDR_LOW_CNT, 8'h40);
        repeat (10) @(posedge clk);
        chk_reg(STC_ADDR_LOW_CNT, 8'h40);
        wr_reg(STC_ADDR_CMD_SET, 8'h0F);
        chk_reg(STC_ADDR_LOW_CNT, 8'h40);
        wr_reg(STC_ADDR_CMD_CLR, 8'h03);
        wr_reg(STC_ADDR_CMD_SET, 8'h07);
        chk_reg(STC_ADDR_LOW_CNT, 8'h40);
        wr_reg(STC_ADDR_CMD_CLR, 8'h03);
        wr_reg(STC_ADDR_LOW_PER, 8'h30);
        wr_reg(STC_ADDR_HIGH_PER, 8'h31);
        wr_reg(STC_ADDR_CMD_SET, 8'h09);
        chk_reg(STC_ADDR_LOW_CNT, 8'h30);
        chk_reg(STC_ADDR_HIGH_CNT, 8'h50);
        wr_reg(STC_ADDR_CMD_CLR, 8'h03);
        wr_reg(STC_ADDR_CMD_SET, 8'h0A);
        chk_reg(STC_ADDR_HIGH_CNT, 8'h31);
        wr_reg(STC_ADDR_CMD_CLR, 8'h03);
        wr_reg(STC_ADDR_LOW_CNT, 8'h11);
        wr_reg(STC_ADDR_CMD_SET, 8'h08);
        chk_reg(STC_ADDR_LOW_CNT, 8'h11);
        wr_reg(STC_ADDR_DEBUG, 8'h01);
        rd_reg(STC_ADDR_LOW_CNT, v);
        repeat (5) @(posedge clk);
        rd_reg(STC_ADDR_LOW_CNT, v2);
        `CHK(v - v2, 8'h07)
        wr_reg(STC_ADDR_DEBUG, 8'h00);
        debug_halt <= 1'b0;
        // ----------------------------------------
        // flags and interrupt line
        // ----------------------------------------
        wr_reg(STC_ADDR_LOW_PER, 8'h05);
        wr_reg(STC_ADDR_HIGH_PER, 8'h06);
        wr_reg(STC_ADDR_HIGH_CNT, 8'h04);
        n = 0;
        do begin
            rd_reg(STC_ADDR_INT_FLAGS, v);
            n++;
        end while (v !== 8'h73 && n < 200);
        if (v !== 8'h73) begin
            failures++;
            test_done();
        end
        wr_reg(STC_ADDR_RUN, 8'h00);
        chk_reg(STC_ADDR_INT_FLAGS, 8'h73);
        chk_out(6'h00, 1'b0);
        wr_reg(STC_ADDR_INT_FLAGS, 8'h10);
        chk_reg(STC_ADDR_INT_FLAGS, 8'h63);
        wr_reg(STC_ADDR_INT_EN, 8'h02);
        chk_out(6'h00, 1'b1);
        wr_reg(STC_ADDR_INT_FLAGS, 8'h02);
        chk_out(6'h00, 1'b0);
        wr_reg(STC_ADDR_INT_EN, 8'h40);
        chk_out(6'h00, 1'b1);
        wr_reg(STC_ADDR_INT_EN, 8'h00);
        chk_out(6'h00, 1'b0);
        chk_reg(STC_ADDR_INT_FLAGS, 8'h61);
        // ----------------------------------------
        // waveform pins while running
        // ----------------------------------------
        wr_reg(STC_ADDR_RUN, 8'h01);
        port_out <= 6'h2A;
        chk_out(6'h2A, 1'b0);
        wr_reg(STC_ADDR_CMP_BASE, 8'hFF);
        wr_reg(STC_ADDR_CMP_BASE + 6'h01, 8'hFF);
        wr_reg(STC_ADDR_CMP_BASE + 6'h02, 8'hFF);
        wr_reg(STC_ADDR_WAVE_MODE, 8'h01);
        wr_reg(STC_ADDR_OUT_EN, 8'h11);
        port_out <= 6'h00;
        chk_out(6'h09, 1'b0);
        wr_reg(STC_ADDR_OUT_LEVEL, 8'h70);
        wr_reg(STC_ADDR_RUN, 8'h00);
        chk_out(6'h38, 1'b0);
        test_done();
    end
endmodule : tb

bind stc_split_timer stc_split_timer_checker chk (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .debug_halt(debug_halt),
    .port_out(port_out), .waveform_pin(waveform_pin), .irq(irq));

`default_nettype wire
